// >>> rtl/rsc_top.sv
//------------------------------------------------------------------------------
// Purpose: system reset combiner, reset cause flags, run/HALT/STOP control,
//          stop unlock key and peripheral block gating
// Assumes: i_core_clk at 25 MHz; interrupt controller, CPU and break strobe on
//          the same clock; pin, power-on, watchdog and supervisor are async
// Notes:   registers over AXI4-Lite, one outstanding write and one read
//------------------------------------------------------------------------------

// How it works
// - any of pin, power-on, watchdog, supervisor or break enters system reset
// - break reset only resets the CPU; special function registers stay as they are
// - cause flags survive resets; each reset sets only its own flag
// - power-on detection sets cause bit 0
// - watchdog overflow reset sets cause bit 2
// - supervisor trip sets cause bit 5
// - external pin reset leaves every cause flag untouched
// - system reset overrides and aborts all activity, HALT and STOP included
// - non-break reset restores every register with a defined initial value except the cause flags
// - after reset stack pointer loads from program words 0000H-0001H
// - program counter from 0002H, or 0004H on break with level one or lower
// - stop request with acceptor enabled enters STOP and disables the acceptor
// - stop acceptor held disabled throughout system reset
// - pending enabled interrupt blocks acceptor enable and HALT/STOP entry
// - standby control bit 0 halt, bit 1 stop; both set is prohibited
// - enabled interrupt in STOP clears stop request and returns to run
// - watchdog interrupt or enabled interrupt ends HALT
// - wake with master enable clear resumes without vectoring
// - block gating holds a peripheral in reset with its clock off
// - disabled block ignores writes and reads initial values until re-enabled
module rsc_top (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_reset_pin_n,
   input wire logic i_power_on_det,
   input wire logic i_watchdog_overflow,
   input wire logic i_supervisor_trip,
   input wire logic i_break_exec,
   input wire logic [1:0] i_exception_level,
   input wire logic i_irq_pending,
   input wire logic i_watchdog_irq,
   input wire logic i_master_irq_enable,
   input wire logic [rsc_pkg::RSC_ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [rsc_pkg::RSC_ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_cpu_reset,
   output logic o_sfr_reset,
   output logic o_vector_load,
   output logic [15:0] o_sp_vector_addr,
   output logic [15:0] o_pc_vector_addr,
   output logic o_halt,
   output logic o_stop,
   output logic o_wake,
   output logic o_wake_take_irq,
   output rsc_pkg::rsc_gate_t o_block_disable
);

   //---------------------------------------------------------------------------
   // reset source synchronisers
   //---------------------------------------------------------------------------
   logic [rsc_pkg::RSC_NSRC-1:0] src_raw;
   logic [rsc_pkg::RSC_NSRC-1:0] src_meta_r;
   logic [rsc_pkg::RSC_NSRC-1:0] src_sync_r;
   logic src_any;

   assign src_raw[rsc_pkg::RSC_SRC_PIN] = ~i_reset_pin_n;
   assign src_raw[rsc_pkg::RSC_SRC_POR] = i_power_on_det;
   assign src_raw[rsc_pkg::RSC_SRC_WDT] = i_watchdog_overflow;
   assign src_raw[rsc_pkg::RSC_SRC_VLS] = i_supervisor_trip;

   for (genvar g = 0; g < rsc_pkg::RSC_NSRC; g++) begin : g_sync
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            src_meta_r[g] <= 1'b0;
            src_sync_r[g] <= 1'b0;
         end else begin
            src_meta_r[g] <= src_raw[g];
            src_sync_r[g] <= src_meta_r[g];
         end
      end
   end

   // reset lasts as long as any source stays asserted
   assign src_any = |src_sync_r;

   //---------------------------------------------------------------------------
   // bus slave
   //---------------------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [15:0] wr_idx_r;
   logic [7:0] wr_byte_r;
   logic wr_lane_r;
   logic wr_fire;
   logic wr_hit;
   logic [15:0] rd_idx;
   logic [31:0] rd_data;
   logic rd_hit;

   assign wr_fire = aw_held_r && w_held_r && !o_bvalid;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         aw_held_r <= 1'b0;
         o_awready <= 1'b1;
         wr_idx_r <= 16'h0000;
      end else if (o_awready && i_awvalid) begin
         aw_held_r <= 1'b1;
         o_awready <= 1'b0;
         wr_idx_r <= i_awaddr[rsc_pkg::RSC_ADDR_W-1:2];
      end else if (o_bvalid && i_bready) begin
         aw_held_r <= 1'b0;
         o_awready <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         w_held_r <= 1'b0;
         o_wready <= 1'b1;
         wr_byte_r <= 8'h00;
         wr_lane_r <= 1'b0;
      end else if (o_wready && i_wvalid) begin
         w_held_r <= 1'b1;
         o_wready <= 1'b0;
         wr_byte_r <= i_wdata[7:0];
         wr_lane_r <= i_wstrb[0];
      end else if (o_bvalid && i_bready) begin
         w_held_r <= 1'b0;
         o_wready <= 1'b1;
      end
   end

   always_comb begin
      unique case (wr_idx_r)
         rsc_pkg::RSC_IDX_CAUSE, rsc_pkg::RSC_IDX_KEY, rsc_pkg::RSC_IDX_SBY,
         rsc_pkg::RSC_IDX_GSER, rsc_pkg::RSC_IDX_GCNV, rsc_pkg::RSC_IDX_GTMR,
         rsc_pkg::RSC_IDX_GPLS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= rsc_pkg::RSC_RESP_OKAY;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp <= wr_hit ? rsc_pkg::RSC_RESP_OKAY : rsc_pkg::RSC_RESP_DECERR;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   logic cause_wr;
   logic key_wr;
   logic sby_wr;
   assign cause_wr = wr_fire && wr_lane_r && wr_idx_r == rsc_pkg::RSC_IDX_CAUSE;
   assign key_wr = wr_fire && wr_lane_r && wr_idx_r == rsc_pkg::RSC_IDX_KEY;
   assign sby_wr = wr_fire && wr_lane_r && wr_idx_r == rsc_pkg::RSC_IDX_SBY;

   //---------------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------------
   logic [7:0] cause_r;
   logic [7:0] cause_nxt;
   rsc_pkg::rsc_gate_t gate_nxt;

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      cause_nxt = cause_wr ? wr_byte_r : cause_r;
      cause_nxt[rsc_pkg::RSC_BIT_POR] = cause_nxt[rsc_pkg::RSC_BIT_POR]
         | src_sync_r[rsc_pkg::RSC_SRC_POR];
      cause_nxt[rsc_pkg::RSC_BIT_WDT] = cause_nxt[rsc_pkg::RSC_BIT_WDT]
         | src_sync_r[rsc_pkg::RSC_SRC_WDT];
      cause_nxt[rsc_pkg::RSC_BIT_VLS] = cause_nxt[rsc_pkg::RSC_BIT_VLS]
         | src_sync_r[rsc_pkg::RSC_SRC_VLS];
   end

   // only the power-up reset seeds the flags; system resets never clear them
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cause_r <= rsc_pkg::RSC_CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   always_comb begin
      gate_nxt = o_block_disable;
      if (wr_fire && wr_lane_r) begin
         unique case (wr_idx_r)
            rsc_pkg::RSC_IDX_GSER: gate_nxt.serial = wr_byte_r;
            rsc_pkg::RSC_IDX_GCNV: gate_nxt.converter = wr_byte_r;
            rsc_pkg::RSC_IDX_GTMR: gate_nxt.timers = wr_byte_r;
            rsc_pkg::RSC_IDX_GPLS: gate_nxt.pulse = wr_byte_r;
            default: gate_nxt = o_block_disable;
         endcase
      end
   end

   // a set bit holds that peripheral in reset with its clock gated; clearing
   // it brings the block back at its initial values
   always_ff @(posedge i_core_clk) begin
      if (i_rst || src_any) begin
         o_block_disable <= {4{rsc_pkg::RSC_GATE_RST}};
      end else begin
         o_block_disable <= gate_nxt;
      end
   end

   assign rd_idx = i_araddr[rsc_pkg::RSC_ADDR_W-1:2];

   // write-only registers answer zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (rd_idx)
         rsc_pkg::RSC_IDX_CAUSE: rd_data = {24'h000000, cause_r};
         rsc_pkg::RSC_IDX_KEY: rd_data = 32'h0000_0000;
         rsc_pkg::RSC_IDX_SBY: rd_data = 32'h0000_0000;
         rsc_pkg::RSC_IDX_GSER: rd_data = {24'h000000, o_block_disable.serial};
         rsc_pkg::RSC_IDX_GCNV: rd_data = {24'h000000, o_block_disable.converter};
         rsc_pkg::RSC_IDX_GTMR: rd_data = {24'h000000, o_block_disable.timers};
         rsc_pkg::RSC_IDX_GPLS: rd_data = {24'h000000, o_block_disable.pulse};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= rsc_pkg::RSC_RESP_OKAY;
      end else if (o_arready && i_arvalid) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= rd_data;
         o_rresp <= rd_hit ? rsc_pkg::RSC_RESP_OKAY : rsc_pkg::RSC_RESP_DECERR;
      end else if (o_rvalid && i_rready) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // operating state
   //---------------------------------------------------------------------------
   rsc_pkg::rsc_state_t state_r;
   rsc_pkg::rsc_state_t state_nxt;
   logic brk_take;
   logic brk_r;
   logic brk_low_r;
   logic [1:0] hold_cnt_r;
   logic acc_r;
   logic key_stage_r;
   logic sby_halt_req;
   logic sby_stop_req;

   assign brk_take = state_r == rsc_pkg::RSC_ST_RUN && i_break_exec && !src_any;
   // both request bits together is the prohibited code and is ignored
   assign sby_halt_req = sby_wr && wr_byte_r[rsc_pkg::RSC_BIT_HALT]
      && !wr_byte_r[rsc_pkg::RSC_BIT_STOP];
   assign sby_stop_req = sby_wr && wr_byte_r[rsc_pkg::RSC_BIT_STOP]
      && !wr_byte_r[rsc_pkg::RSC_BIT_HALT];

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rsc_pkg::RSC_ST_RESET: begin
            if (hold_cnt_r == 2'h0) begin
               state_nxt = rsc_pkg::RSC_ST_VECTOR;
            end
         end
         rsc_pkg::RSC_ST_VECTOR: state_nxt = rsc_pkg::RSC_ST_RUN;
         rsc_pkg::RSC_ST_RUN: begin
            if (brk_take) begin
               state_nxt = rsc_pkg::RSC_ST_RESET;
            end else if (sby_halt_req && !i_irq_pending) begin
               state_nxt = rsc_pkg::RSC_ST_HALT;
            end else if (sby_stop_req && acc_r && !i_irq_pending) begin
               state_nxt = rsc_pkg::RSC_ST_STOP;
            end
         end
         rsc_pkg::RSC_ST_HALT: begin
            if (i_irq_pending || i_watchdog_irq) begin
               state_nxt = rsc_pkg::RSC_ST_RUN;
            end
         end
         rsc_pkg::RSC_ST_STOP: begin
            if (i_irq_pending) begin
               state_nxt = rsc_pkg::RSC_ST_RUN;
            end
         end
         default: state_nxt = rsc_pkg::RSC_ST_RESET;
      endcase
      if (src_any) begin
         state_nxt = rsc_pkg::RSC_ST_RESET;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_r <= rsc_pkg::RSC_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // a break reset lasts a fixed number of cycles, just long enough for the core
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         hold_cnt_r <= 2'h0;
      end else if (brk_take) begin
         hold_cnt_r <= rsc_pkg::RSC_BRK_HOLD;
      end else if (hold_cnt_r != 2'h0) begin
         hold_cnt_r <= hold_cnt_r - 2'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || src_any) begin
         brk_r <= 1'b0;
         brk_low_r <= 1'b0;
      end else if (brk_take) begin
         brk_r <= 1'b1;
         brk_low_r <= i_exception_level <= rsc_pkg::RSC_BRK_LVL_MAX;
      end
   end

   //---------------------------------------------------------------------------
   // stop unlock key
   //---------------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst || state_nxt == rsc_pkg::RSC_ST_RESET) begin
         acc_r <= 1'b0;
         key_stage_r <= 1'b0;
      end else if (state_nxt == rsc_pkg::RSC_ST_STOP) begin
         acc_r <= 1'b0;
         key_stage_r <= 1'b0;
      end else if (key_wr) begin
         if (wr_byte_r[7:4] == rsc_pkg::RSC_KEY_FIRST) begin
            key_stage_r <= 1'b1;
         end else if (key_stage_r && wr_byte_r[7:4] == rsc_pkg::RSC_KEY_SECOND) begin
            key_stage_r <= 1'b0;
            acc_r <= !i_irq_pending;
         end else begin
            key_stage_r <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------------------
   // outputs to the core
   //---------------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_cpu_reset <= 1'b1;
         o_sfr_reset <= 1'b1;
         o_vector_load <= 1'b0;
         o_sp_vector_addr <= rsc_pkg::RSC_SP_VEC;
         o_pc_vector_addr <= rsc_pkg::RSC_PC_VEC;
      end else begin
         o_cpu_reset <= state_nxt == rsc_pkg::RSC_ST_RESET;
         o_sfr_reset <= src_any;
         o_vector_load <= state_nxt == rsc_pkg::RSC_ST_VECTOR;
         o_sp_vector_addr <= rsc_pkg::RSC_SP_VEC;
         o_pc_vector_addr <= (brk_r && brk_low_r) ? rsc_pkg::RSC_PC_VEC_BRK
            : rsc_pkg::RSC_PC_VEC;
      end
   end

   logic leaving_standby;
   assign leaving_standby = (state_r == rsc_pkg::RSC_ST_HALT || state_r == rsc_pkg::RSC_ST_STOP)
      && state_nxt == rsc_pkg::RSC_ST_RUN;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_halt <= 1'b0;
         o_stop <= 1'b0;
         o_wake <= 1'b0;
         o_wake_take_irq <= 1'b0;
      end else begin
         o_halt <= state_nxt == rsc_pkg::RSC_ST_HALT;
         o_stop <= state_nxt == rsc_pkg::RSC_ST_STOP;
         o_wake <= leaving_standby;
         o_wake_take_irq <= leaving_standby && i_master_irq_enable;
      end
   end

   //---------------------------------------------------------------------------
   // checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   cause_sticky_a: assert property (
      !(|src_sync_r[2:0]) && !cause_wr |=> $stable(cause_r))
      else $error("cause flags changed without a cause");
   por_flag_a: assert property (
      src_sync_r[rsc_pkg::RSC_SRC_POR] |=> cause_r[rsc_pkg::RSC_BIT_POR])
      else $error("power-on flag not set");
   wdt_flag_a: assert property (
      src_sync_r[rsc_pkg::RSC_SRC_WDT] |=> cause_r[rsc_pkg::RSC_BIT_WDT])
      else $error("watchdog flag not set");
   vls_flag_a: assert property (
      src_sync_r[rsc_pkg::RSC_SRC_VLS] |=> cause_r[rsc_pkg::RSC_BIT_VLS])
      else $error("supervisor flag not set");
   pin_no_flag_a: assert property (
      src_sync_r == 4'h8 && !cause_wr |=> $stable(cause_r))
      else $error("pin reset touched cause flags");
   reset_abort_a: assert property (
      src_any |=> o_cpu_reset && !o_halt && !o_stop)
      else $error("reset did not abort activity");
   pin_sync_a: assert property (
      !i_reset_pin_n [*3] |-> ##[0:1] o_cpu_reset)
      else $error("pin reset not applied after synchronisation");
   brk_keeps_sfr_a: assert property (
      brk_take |=> !o_sfr_reset && $stable(o_block_disable) ##1 o_cpu_reset)
      else $error("break reset disturbed registers");
   sfr_init_a: assert property (
      src_any |=> o_block_disable == {4{rsc_pkg::RSC_GATE_RST}})
      else $error("gates not restored on reset");
   pc_vector_a: assert property (
      o_vector_load |-> o_pc_vector_addr == ((brk_r && brk_low_r)
         ? rsc_pkg::RSC_PC_VEC_BRK : rsc_pkg::RSC_PC_VEC))
      else $error("wrong program counter vector");
   key_unlock_a: assert property (
      key_wr && key_stage_r && wr_byte_r[7:4] == rsc_pkg::RSC_KEY_SECOND
      && !i_irq_pending && !src_any && state_r == rsc_pkg::RSC_ST_RUN && !brk_take |=> acc_r)
      else $error("acceptor not enabled by key");
   key_cancel_a: assert property (
      key_wr && wr_byte_r[7:4] != rsc_pkg::RSC_KEY_FIRST |=> !key_stage_r)
      else $error("partial key not cancelled");
   acc_reset_a: assert property (
      o_cpu_reset |-> !acc_r)
      else $error("acceptor enabled during reset");
   stop_entry_a: assert property (
      $rose(o_stop) |-> !acc_r && $past(acc_r))
      else $error("stop entry without acceptor handling");
   no_standby_pend_a: assert property (
      $rose(o_halt) || $rose(o_stop) |-> !$past(i_irq_pending))
      else $error("standby entered with pending interrupt");
   stop_wake_a: assert property (
      o_stop && i_irq_pending && !src_any |=> !o_stop && o_wake)
      else $error("interrupt did not end stop");
   halt_wake_a: assert property (
      o_halt && i_watchdog_irq && !src_any |=> !o_halt && o_wake)
      else $error("watchdog interrupt did not end halt");
   wake_novec_a: assert property (
      o_wake && !$past(i_master_irq_enable) |-> !o_wake_take_irq)
      else $error("vectored with master enable clear");

endmodule // rsc_top

// >>> rtl/rsc_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and types of the reset and standby control block
// Assumes: registers sit on a 32-bit AXI4-Lite slave, one word per index
// Notes:   byte address of a register is four times its index
//------------------------------------------------------------------------------
package rsc_pkg;

   //---------------------------------------------------------------------------
   // register map
   //---------------------------------------------------------------------------
   localparam int RSC_ADDR_W = 18;
   localparam logic [15:0] RSC_IDX_CAUSE = 16'hF001;
   localparam logic [15:0] RSC_IDX_KEY = 16'hF008;
   localparam logic [15:0] RSC_IDX_SBY = 16'hF009;
   localparam logic [15:0] RSC_IDX_GSER = 16'hF02A;
   localparam logic [15:0] RSC_IDX_GCNV = 16'hF02C;
   localparam logic [15:0] RSC_IDX_GTMR = 16'hF02E;
   localparam logic [15:0] RSC_IDX_GPLS = 16'hF02F;

   //---------------------------------------------------------------------------
   // fields and values after reset
   //---------------------------------------------------------------------------
   localparam int RSC_BIT_POR = 0;
   localparam int RSC_BIT_WDT = 2;
   localparam int RSC_BIT_VLS = 5;
   localparam int RSC_BIT_HALT = 0;
   localparam int RSC_BIT_STOP = 1;
   localparam logic [7:0] RSC_CAUSE_RST = 8'h01;
   localparam logic [7:0] RSC_GATE_RST = 8'h00;
   localparam logic [3:0] RSC_KEY_FIRST = 4'h5;
   localparam logic [3:0] RSC_KEY_SECOND = 4'hA;
   localparam logic [1:0] RSC_BRK_HOLD = 2'h2;
   localparam logic [15:0] RSC_SP_VEC = 16'h0000;
   localparam logic [15:0] RSC_PC_VEC = 16'h0002;
   localparam logic [15:0] RSC_PC_VEC_BRK = 16'h0004;
   localparam logic [1:0] RSC_BRK_LVL_MAX = 2'h1;
   localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSC_RESP_DECERR = 2'h3;

   // index of each asynchronous reset source in the synchroniser vector
   localparam int RSC_SRC_VLS = 0;
   localparam int RSC_SRC_WDT = 1;
   localparam int RSC_SRC_POR = 2;
   localparam int RSC_SRC_PIN = 3;
   localparam int RSC_NSRC = 4;

   typedef enum logic [2:0] {
      RSC_ST_RESET = 3'h0,
      RSC_ST_VECTOR = 3'h1,
      RSC_ST_RUN = 3'h2,
      RSC_ST_HALT = 3'h3,
      RSC_ST_STOP = 3'h4
   } rsc_state_t;

   typedef struct packed {
      logic [7:0] pulse;
      logic [7:0] timers;
      logic [7:0] converter;
      logic [7:0] serial;
   } rsc_gate_t;

endpackage : rsc_pkg

// >>> dv/rsc_cpu_model.sv
// Purpose: CPU core stand-in that executes a break and takes the program counter reset vector
// Assumes: runs on the block's clock
// Notes: a break is only issued while the core is out of reset
module rsc_cpu_model (
   input wire logic i_core_clk,
   input wire logic i_cpu_reset,
   input wire logic i_vector_load,
   input wire logic [15:0] i_pc_vector_addr,
   input wire logic i_do_break,
   output logic o_break_exec,
   output logic [15:0] o_pc_loaded
);
   timeunit 1ns;
   timeprecision 1ns;
   // one-cycle strobe, as a single executed instruction would give
   always_ff @(posedge i_core_clk) begin
      o_break_exec <= i_do_break && !i_cpu_reset && !o_break_exec;
      if (i_vector_load) begin
         o_pc_loaded <= i_pc_vector_addr;
      end
   end
endmodule // rsc_cpu_model

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the reset and standby control block
// Assumes: AXI4-Lite master, one transfer at a time
// Notes: outputs are read right after the edge, so they hold their sampled values
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, pin_n = 1, por = 0, wdo = 0, sup = 0, irq = 0, wirq = 0, master_irq_enable = 0;
   logic [1:0] lvl = 2'h1;
   logic [17:0] awa = 18'h0, ara = 18'h0;
   logic [31:0] wd = 32'h0, rd, rdat;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, break_instruction = 0, bx, awr, wr_r, bv, arr, rv;
   logic cres, sres, vld, halt_request_bit, stop_request_bit, wk, wki;
   logic [1:0] bresp, rresp, lresp;
   logic [15:0] spa, pca, pcl;
   rsc_pkg::rsc_gate_t gate;
   int error_cnt = 0, checked = 0;
   initial forever #20 clk = ~clk;
   rsc_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_reset_pin_n(pin_n), .i_power_on_det(por),
      .i_watchdog_overflow(wdo), .i_supervisor_trip(sup), .i_break_exec(bx),
      .i_exception_level(lvl), .i_irq_pending(irq), .i_watchdog_irq(wirq),
      .i_master_irq_enable(master_irq_enable), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
      .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp),
      .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
      .o_rdata(rd), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr), .o_cpu_reset(cres),
      .o_sfr_reset(sres), .o_vector_load(vld), .o_sp_vector_addr(spa),
      .o_pc_vector_addr(pca), .o_halt(halt_request_bit), .o_stop(stop_request_bit), .o_wake(wk),
      .o_wake_take_irq(wki), .o_block_disable(gate));
   rsc_cpu_model cpu_u (.i_core_clk(clk), .i_cpu_reset(cres), .i_vector_load(vld),
      .i_pc_vector_addr(pca), .i_do_break(break_instruction), .o_break_exec(bx), .o_pc_loaded(pcl));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic timeout;
      error_cnt++;
      $display("wrong value t=%0t wait ran out", $time);
      wrap_up();
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      awa <= {idx, 2'h0};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
         if (bv) break;
      end
      if (n == 50) timeout();
      lresp = bresp;
      br <= 1'b0;
   endtask
   task automatic rdr(input logic [15:0] idx);
      int n;
      @(posedge clk);
      ara <= {idx, 2'h0};
      arv <= 1'b1;
      rr <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      if (n == 50) timeout();
      rdat = rd;
      lresp = rresp;
      rr <= 1'b0;
   endtask
   task automatic wait_ev(input bit wake);
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (wake ? wk : vld) return;
      end
      timeout();
   endtask
   task automatic s_regs;
      rdr(rsc_pkg::RSC_IDX_CAUSE);
      chk(rdat, 32'h01);
      rdr(rsc_pkg::RSC_IDX_KEY);
      chk(rdat, 32'h00);
      rdr(16'hF003);
      chk(lresp, rsc_pkg::RSC_RESP_DECERR);
      wr(rsc_pkg::RSC_IDX_GSER, 8'hA5);
      chk(lresp, rsc_pkg::RSC_RESP_OKAY);
      chk(gate.serial, 8'hA5);
      wr(16'hF003, 8'h00);
      chk(lresp, rsc_pkg::RSC_RESP_DECERR);
   endtask
   task automatic s_cause;
      wr(rsc_pkg::RSC_IDX_CAUSE, 8'h00);
      wdo <= 1'b1;
      repeat (4) @(posedge clk);
      chk({cres, sres}, 2'h3);
      wdo <= 1'b0;
      wait_ev(0);
      rdr(rsc_pkg::RSC_IDX_CAUSE);
      chk(rdat, 32'h04);
      chk(gate.serial, 8'h00);
      pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      pin_n <= 1'b1;
      wait_ev(0);
      rdr(rsc_pkg::RSC_IDX_CAUSE);
      chk(rdat, 32'h04);
      sup <= 1'b1;
      repeat (4) @(posedge clk);
      sup <= 1'b0;
      wait_ev(0);
      rdr(rsc_pkg::RSC_IDX_CAUSE);
      chk(rdat, 32'h24);
   endtask
   task automatic s_break(input logic [1:0] l, input logic [15:0] pce);
      wr(rsc_pkg::RSC_IDX_GTMR, 8'h3C);
      lvl <= l;
      break_instruction <= 1'b1;
      @(posedge clk);
      break_instruction <= 1'b0;
      repeat (2) @(posedge clk);
      chk({cres, sres}, 2'h2);
      wait_ev(0);
      @(posedge clk);
      chk(pcl, pce);
      chk(spa, 16'h0000);
      chk(gate.timers, 8'h3C);
   endtask
   task automatic s_stop;
      wr(rsc_pkg::RSC_IDX_KEY, 8'h57);
      wr(rsc_pkg::RSC_IDX_KEY, 8'h12);
      wr(rsc_pkg::RSC_IDX_KEY, 8'hA0);
      wr(rsc_pkg::RSC_IDX_SBY, 8'h02);
      @(posedge clk);
      chk(stop_request_bit, 1'b0);
      wr(rsc_pkg::RSC_IDX_KEY, 8'h50);
      wr(rsc_pkg::RSC_IDX_GPLS, 8'h01);
      wr(rsc_pkg::RSC_IDX_KEY, 8'hA3);
      wr(rsc_pkg::RSC_IDX_SBY, 8'h02);
      @(posedge clk);
      chk(stop_request_bit, 1'b1);
      irq <= 1'b1;
      wait_ev(1);
      chk(wki, 1'b0);
      @(posedge clk);
      chk(stop_request_bit, 1'b0);
      wr(rsc_pkg::RSC_IDX_SBY, 8'h01);
      @(posedge clk);
      chk(halt_request_bit, 1'b0);
      irq <= 1'b0;
      wr(rsc_pkg::RSC_IDX_SBY, 8'h02);
      @(posedge clk);
      chk(stop_request_bit, 1'b0);
      wr(rsc_pkg::RSC_IDX_SBY, 8'h01);
      @(posedge clk);
      chk(halt_request_bit, 1'b1);
      wirq <= 1'b1;
      master_irq_enable <= 1'b1;
      wait_ev(1);
      chk(wki, 1'b1);
      wirq <= 1'b0;
      @(posedge clk);
      chk(halt_request_bit, 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait_ev(0);
      s_regs();
      s_cause();
      s_break(2'h1, 16'h0004);
      s_break(2'h2, 16'h0002);
      s_stop();
      wrap_up();
   end
endmodule // tb_top
